// [verilog/bus_params.svh]
`ifndef BUS_PARAMS_SVH
`define BUS_PARAMS_SVH
// function codes on the three function lines
`define FN_NOP 3'h0
`define FN_CMD 3'h1
`define FN_WDATA 3'h2
`define FN_NDR 3'h3
`define FN_GRD 3'h4
`define FN_CRD 3'h6
// command codes in the command field
`define CMD_READ 4'h1
`define CMD_ILOCK 4'h2
`define CMD_TAGBAD 4'h5
`define CMD_UNLOCK 4'h6
`define CMD_WMASK 4'h7
// length codes
`define LEN_HEXA 2'h0
`define LEN_LONG 2'h1
`define LEN_QUAD 2'h2
`define LEN_OCTA 2'h3
// non-data response codes
`define NDR_OK 2'h0
`define NDR_LOCKED 2'h1
`define NDR_TAGGED 2'h2
`define NDR_UNCORR 2'h3
// field positions in a command cycle, and the code of a non-data response
`define CMD_LO 60
`define MASK_LO 32
`define LEN_LO 30
`define NDR_LO 62
`define IO_BIT 29
`define LW_BIT 2
`define WORD_BIT 1
`define QW_LO 3
`endif

// [verilog/bus_pkg.sv]
`default_nettype none
`include "bus_params.svh"
package bus_pkg;
	// responder states
	typedef enum logic [2:0] {
		R_IDLE = 3'b001,
		R_WDATA = 3'b010,
		R_RESP = 3'b100
	} rsp_st_e;
	// commander states
	typedef enum logic [2:0] {
		C_IDLE = 3'b001,
		C_WDATA = 3'b010,
		C_WAIT = 3'b100
	} cmd_st_e;
	// bus drive of one end
	typedef struct packed {
		logic oe;
		logic [2:0] func;
		logic [4:0] id;
		logic [63:0] data;
		logic par;
	} drive_s;
	typedef struct packed {
		rsp_st_e st;
		logic [3:0] cmd;
		logic [1:0] len;
		logic [29:0] addr;
		logic [15:0] mask;
		logic [4:0] cid;
		logic [1:0] cnt;
		logic [1:0] last;
		logic ndr;
		logic [1:0] code;
		logic corr;
		logic lock;
		logic perr;
		drive_s drv;
	} rsp_state_s;
	typedef struct packed {
		cmd_st_e st;
		logic [3:0] cmd;
		logic [1:0] len;
		logic [29:0] addr;
		logic [15:0] mask;
		logic [63:0] wd0;
		logic [63:0] wd1;
		logic [1:0] cnt;
		logic [1:0] last;
		logic ready;
		logic rd_valid;
		logic [63:0] rd_data;
		logic rd_corr;
		logic seq_err;
		logic ndr_valid;
		logic [1:0] ndr_code;
		logic perr;
		drive_s drv;
	} cmd_state_s;
	// index of the last response cycle for a read length
	function automatic logic [1:0] resp_last(input logic [1:0] len);
		if (len == `LEN_HEXA)
			return 2'h3;
		else if (len == `LEN_OCTA)
			return 2'h1;
		else
			return 2'h0;
	endfunction
	// even parity bit over data, function and identifier
	function automatic logic bus_par(input logic [2:0] f,
		input logic [4:0] i, input logic [63:0] d);
		return ^{d, f, i};
	endfunction
endpackage
`default_nettype wire

// [verilog/bus_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface bus_if;
	// commander end drive
	logic c_oe;
	logic [2:0] c_func;
	logic [4:0] c_id;
	logic [63:0] c_data;
	logic c_par;
	// responder end drive
	logic r_oe;
	logic [2:0] r_func;
	logic [4:0] r_id;
	logic [63:0] r_data;
	logic r_par;
	// resolved bus: undriven lines read zero, which is idle with good parity
	logic [2:0] bus_func;
	logic [4:0] commander_identifier_lines;
	logic [63:0] bus_data;
	logic bus_parity_line;
	assign bus_func = (c_oe ? c_func : 3'h0) | (r_oe ? r_func : 3'h0);
	assign commander_identifier_lines = (c_oe ? c_id : 5'h00)
		| (r_oe ? r_id : 5'h00);
	assign bus_data = (c_oe ? c_data : 64'h0) | (r_oe ? r_data : 64'h0);
	assign bus_parity_line = (c_oe & c_par) | (r_oe & r_par);
	modport commander (output c_oe, output c_func, output c_id,
		output c_data, output c_par, input bus_func,
		input commander_identifier_lines, input bus_data,
		input bus_parity_line);
	modport responder (output r_oe, output r_func, output r_id,
		output r_data, output r_par, input bus_func,
		input commander_identifier_lines, input bus_data,
		input bus_parity_line);
endinterface
`default_nettype wire

// [verilog/bus_responder.sv]
// Operation
// RQ1: write data cycle uses 010, commander id
// RQ2: longword writes use only low 32 bits
// RQ3: parity always covers all 64 data bits
// RQ4: read data codes 10x good, 11x corrected
// RQ5: low function bit marks even/odd data cycle
// RQ6: read response carries commander id and data
// RQ7: longword read data sits in low 32 bits
// RQ8: non-data response 011, code in top bits
// RQ9: codes: successful, locked, tagged, uncorrectable
// RQ10: deferred I/O write later answered successful
// RQ11: tagged location reads answer bad-data-tagged
// RQ12: uncorrectable location answers uncorrectable response
// RQ13: reads wrap; octaword writes naturally aligned
// RQ14: word/byte modes keep low address bits
// RQ15: word device returns selected word, A1 chooses
// RQ16: longword device ignores A1, full longword
// RQ17: read command latched, data returned later
// RQ18: commander latches only responses with its id
// RQ19: interlocked read locks or answers locked
// RQ20: unlock write clears lock, writes masked
// RQ21: masked write, one bit per byte
// RQ22: partial quadword merged, full quadword overwritten
// RQ23: length codes hexa, long, quad, octa
`timescale 1ns/1ps
`default_nettype none
`include "bus_params.svh"
module bus_responder #(
	parameter int AW = 4 // quadword address bits of the memory
) (
	input wire logic clk,
	input wire logic rst,
	bus_if.responder bus,
	input wire logic word_mode, // longword reads use word selection
	input wire logic corr_inject, // mark reads as ecc corrected
	input wire logic uncorr_inject, // mark reads as uncorrectable
	output logic locked, // memory interlock held
	output logic parity_err // one-cycle pulse on bad bus parity
);
	bus_pkg::rsp_state_s s; // registered state
	bus_pkg::rsp_state_s n; // next state
	logic [63:0] mem [0:(1<<AW)-1]; // quadword storage
	logic [(1<<AW)-1:0] tag; // tag-bad-data marks per quadword
	logic mem_we; // quadword write strobe
	logic [AW-1:0] widx; // quadword written
	logic [63:0] wval; // merged quadword
	logic tag_set; // mark quadword bad
	logic tag_clr; // clear bad mark
	logic [AW-1:0] tidx; // quadword whose mark changes
	logic rx_ok; // received parity is good
	logic [AW-1:0] qi_bus; // quadword addressed on the bus
	logic [AW-1:0] qi; // quadword of the latched command
	logic [AW-1:0] ridx; // quadword of this response cycle
	logic [63:0] rq; // stored quadword being read
	logic [31:0] lw; // selected longword
	logic [63:0] wd; // write data aligned to the quadword
	logic [7:0] m8; // byte enables for this quadword

	assign locked = s.lock;
	assign parity_err = s.perr;
	assign bus.r_oe = s.drv.oe;
	assign bus.r_func = s.drv.func;
	assign bus.r_id = s.drv.id;
	assign bus.r_data = s.drv.data;
	assign bus.r_par = s.drv.par;

	// next state, bus drive and memory strobes
	always_comb
	begin
		n = s;
		n.perr = 1'b0;
		n.drv.oe = 1'b0;
		n.drv.func = `FN_NOP;
		n.drv.id = 5'h00;
		n.drv.data = 64'h0;
		mem_we = 1'b0;
		tag_set = 1'b0;
		tag_clr = 1'b0;
		wd = bus.bus_data;
		m8 = 8'h00;
		lw = 32'h0;
		// check over the whole 64 bits, unspecified ones too
		rx_ok = bus.bus_parity_line == bus_pkg::bus_par(bus.bus_func,
			bus.commander_identifier_lines, bus.bus_data); // RQ3
		qi_bus = bus.bus_data[`QW_LO +: AW];
		qi = s.addr[`QW_LO +: AW];
		tidx = qi;
		// wrapped reads start at the addressed quadword
		if (s.len == `LEN_HEXA)
			ridx = {qi[AW-1:2], 2'(qi[1:0] + s.cnt)}; // RQ13
		else if (s.len == `LEN_OCTA)
			ridx = {qi[AW-1:1], qi[0] ^ s.cnt[0]}; // RQ13
		else
			ridx = qi;
		// octaword writes ignore the low address bits
		if (s.len == `LEN_OCTA)
			widx = {qi[AW-1:1], s.cnt[0]}; // RQ13
		else
			widx = qi;
		rq = mem[ridx];
		wval = mem[widx];
		if (bus.bus_func != `FN_NOP && !rx_ok)
			n.perr = 1'b1;
		case (s.st)
			bus_pkg::R_IDLE:
			begin
				// a command is latched only when its parity is good
				if (rx_ok && bus.bus_func == `FN_CMD)
				begin
					n.cmd = bus.bus_data[`CMD_LO +: 4];
					n.mask = bus.bus_data[`MASK_LO +: 16];
					n.len = bus.bus_data[`LEN_LO +: 2]; // RQ23
					n.addr = bus.bus_data[29:0];
					n.cid = bus.commander_identifier_lines;
					n.cnt = 2'h0;
					tidx = qi_bus;
					if (n.cmd == `CMD_READ || n.cmd == `CMD_ILOCK)
					begin
						n.last = bus_pkg::resp_last(n.len); // RQ17
						n.corr = corr_inject;
						n.ndr = 1'b1;
						n.st = bus_pkg::R_RESP; // RQ17
						// error answers take priority over the lock test
						if (tag[qi_bus])
							n.code = `NDR_TAGGED; // RQ11
						else if (uncorr_inject)
							n.code = `NDR_UNCORR; // RQ12
						else if (n.cmd == `CMD_ILOCK && s.lock)
							n.code = `NDR_LOCKED; // RQ19
						else
							n.ndr = 1'b0;
						if (n.cmd == `CMD_ILOCK && !n.ndr)
							n.lock = 1'b1; // RQ19
					end
					else if (n.cmd == `CMD_WMASK || n.cmd == `CMD_UNLOCK)
					begin
						// one data cycle, two for an octaword
						n.last = {1'b0, n.len == `LEN_OCTA}; // RQ21
						n.st = bus_pkg::R_WDATA;
					end
					else if (n.cmd == `CMD_TAGBAD)
						tag_set = 1'b1;
				end
			end
			bus_pkg::R_WDATA:
			begin
				if (rx_ok && bus.bus_func == `FN_WDATA) // RQ1
				begin
					m8 = s.cnt[0] ? s.mask[15:8] : s.mask[7:0]; // RQ21
					// a longword rides in the low half of the data lines
					if (s.len == `LEN_LONG)
					begin
						wd = s.addr[`LW_BIT] ? {bus.bus_data[31:0], 32'h0}
							: {32'h0, bus.bus_data[31:0]}; // RQ2
						m8 = s.addr[`LW_BIT] ? {s.mask[3:0], 4'h0}
							: {4'h0, s.mask[3:0]}; // RQ2
					end
					// partial quadwords keep the old bytes, a full mask
					// simply overwrites every byte
					for (int b = 0; b < 8; b++)
						if (m8[b])
							wval[b*8 +: 8] = wd[b*8 +: 8]; // RQ22
					mem_we = 1'b1;
					tidx = widx;
					tag_clr = &m8;
					n.cnt = 2'(s.cnt + 2'h1);
					if (s.cnt == s.last)
					begin
						n.st = bus_pkg::R_IDLE;
						if (s.cmd == `CMD_UNLOCK)
							n.lock = 1'b0; // RQ20
						// I/O writes are deferred and finished later
						if (s.addr[`IO_BIT])
						begin
							n.ndr = 1'b1;
							n.code = `NDR_OK; // RQ10
							n.st = bus_pkg::R_RESP;
						end
					end
				end
			end
			bus_pkg::R_RESP:
			begin
				n.drv.oe = 1'b1;
				n.drv.id = s.cid; // RQ6
				if (s.ndr)
				begin
					n.drv.func = `FN_NDR; // RQ8
					n.drv.data[`NDR_LO +: 2] = s.code; // RQ9
					n.st = bus_pkg::R_IDLE;
				end
				else
				begin
					// sequence bit follows the data cycle number
					n.drv.func = (s.corr ? `FN_CRD : `FN_GRD)
						| {2'h0, s.cnt[0]}; // RQ4 RQ5
					n.drv.data = rq; // RQ6
					if (s.len == `LEN_LONG)
					begin
						lw = s.addr[`LW_BIT] ? rq[63:32] : rq[31:0];
						// the unselected word is zero, parity still good
						if (word_mode)
							n.drv.data = s.addr[`WORD_BIT]
								? {32'h0, lw[31:16], 16'h0}
								: {48'h0, lw[15:0]}; // RQ15 RQ14
						else
							n.drv.data = {32'h0, lw}; // RQ16 RQ7
					end
					n.cnt = 2'(s.cnt + 2'h1);
					if (s.cnt == s.last)
						n.st = bus_pkg::R_IDLE;
				end
			end
			default:
				n.st = bus_pkg::R_IDLE;
		endcase
		n.drv.par = bus_pkg::bus_par(n.drv.func, n.drv.id,
			n.drv.data); // RQ3 RQ8
	end

	// state register
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s <= '0;
			s.st <= bus_pkg::R_IDLE;
		end
		else
			s <= n;
	end

	// storage has no reset; tag marks do
	always_ff @(posedge clk)
	begin
		if (mem_we)
			mem[widx] <= wval;
		if (rst)
			tag <= '0;
		else if (tag_set)
			tag[tidx] <= 1'b1; // RQ11
		else if (tag_clr)
			tag[tidx] <= 1'b0;
	end
endmodule
`default_nettype wire

// [verilog/bus_commander.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bus_params.svh"
module bus_commander #(
	parameter logic [4:0] MY_ID = 5'h02 // own commander identifier
) (
	input wire logic clk,
	input wire logic rst,
	bus_if.commander bus,
	input wire logic req_valid, // request held until taken
	input wire logic [3:0] req_cmd,
	input wire logic [1:0] req_len,
	input wire logic [29:0] req_addr,
	input wire logic [15:0] req_mask,
	input wire logic [63:0] req_wdata0, // first write quadword
	input wire logic [63:0] req_wdata1, // second, octaword only
	output logic req_ready, // idle and able to take a request
	output logic rd_valid, // pulse per read data cycle
	output logic [63:0] rd_data,
	output logic rd_corr, // data was ecc corrected
	output logic seq_err, // sequence bit mismatch, a cycle was lost
	output logic ndr_valid, // pulse on a non-data response
	output logic [1:0] ndr_code,
	output logic parity_err // pulse on bad bus parity
);
	bus_pkg::cmd_state_s s; // registered state
	bus_pkg::cmd_state_s n; // next state
	logic rx_ok; // received parity good
	logic mine; // cycle addressed to this commander

	assign req_ready = s.ready;
	assign rd_valid = s.rd_valid;
	assign rd_data = s.rd_data;
	assign rd_corr = s.rd_corr;
	assign seq_err = s.seq_err;
	assign ndr_valid = s.ndr_valid;
	assign ndr_code = s.ndr_code;
	assign parity_err = s.perr;
	assign bus.c_oe = s.drv.oe;
	assign bus.c_func = s.drv.func;
	assign bus.c_id = s.drv.id;
	assign bus.c_data = s.drv.data;
	assign bus.c_par = s.drv.par;

	// next state and bus drive
	always_comb
	begin
		n = s;
		n.rd_valid = 1'b0;
		n.seq_err = 1'b0;
		n.ndr_valid = 1'b0;
		n.perr = 1'b0;
		n.drv = '0;
		rx_ok = bus.bus_parity_line == bus_pkg::bus_par(bus.bus_func,
			bus.commander_identifier_lines, bus.bus_data); // RQ3
		mine = rx_ok && bus.commander_identifier_lines == MY_ID; // RQ18
		if (bus.bus_func != `FN_NOP && !rx_ok)
			n.perr = 1'b1;
		case (s.st)
			bus_pkg::C_IDLE:
			begin
				if (req_valid && s.ready)
				begin
					n.ready = 1'b0;
					n.cmd = req_cmd;
					n.len = req_len;
					n.addr = req_addr;
					n.wd0 = req_wdata0;
					n.wd1 = req_wdata1;
					n.cnt = 2'h0;
					n.drv.oe = 1'b1;
					n.drv.func = `FN_CMD; // RQ17
					n.drv.id = MY_ID;
					n.drv.data = {req_cmd, 12'h0, req_mask, req_len,
						req_addr}; // RQ23
					if (req_cmd == `CMD_WMASK || req_cmd == `CMD_UNLOCK)
					begin
						n.last = {1'b0, req_len == `LEN_OCTA}; // RQ21
						n.st = bus_pkg::C_WDATA;
					end
					else if (req_cmd == `CMD_READ || req_cmd == `CMD_ILOCK)
					begin
						n.last = bus_pkg::resp_last(req_len);
						n.st = bus_pkg::C_WAIT;
					end
				end
				else
					n.ready = 1'b1;
			end
			bus_pkg::C_WDATA:
			begin
				n.drv.oe = 1'b1;
				n.drv.func = `FN_WDATA; // RQ1
				n.drv.id = MY_ID; // RQ1
				// longword data sits in the low half as supplied
				n.drv.data = s.cnt[0] ? s.wd1 : s.wd0; // RQ2
				n.cnt = 2'(s.cnt + 2'h1);
				if (s.cnt == s.last)
				begin
					// an I/O write waits for its deferred completion
					if (s.addr[`IO_BIT])
					begin
						n.cnt = 2'h0;
						n.last = 2'h0;
						n.st = bus_pkg::C_WAIT; // RQ10
					end
					else
						n.st = bus_pkg::C_IDLE;
				end
			end
			bus_pkg::C_WAIT:
			begin
				if (mine && bus.bus_func[2])
				begin
					n.rd_valid = 1'b1;
					n.rd_data = bus.bus_data;
					n.rd_corr = bus.bus_func[1]; // RQ4
					n.seq_err = bus.bus_func[0] != s.cnt[0]; // RQ5
					n.cnt = 2'(s.cnt + 2'h1);
					if (s.cnt == s.last)
						n.st = bus_pkg::C_IDLE;
				end
				else if (mine && bus.bus_func == `FN_NDR)
				begin
					n.ndr_valid = 1'b1;
					n.ndr_code = bus.bus_data[`NDR_LO +: 2]; // RQ9
					n.st = bus_pkg::C_IDLE;
				end
			end
			default:
				n.st = bus_pkg::C_IDLE;
		endcase
		n.drv.par = bus_pkg::bus_par(n.drv.func, n.drv.id,
			n.drv.data); // RQ3
	end

	// state register
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s <= '0;
			s.st <= bus_pkg::C_IDLE;
		end
		else
			s <= n;
	end
endmodule
`default_nettype wire

// [dv/bus_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bus_params.svh"
// watches the shared bus between the two ends
module bus_asserts #(
	parameter logic [4:0] MY_ID = 5'h02 // commander id expected
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic c_oe,
	input wire logic r_oe,
	input wire logic [2:0] bus_func,
	input wire logic [4:0] commander_identifier_lines,
	input wire logic [63:0] bus_data,
	input wire logic bus_parity_line
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// command cycle decodes
	wire logic [3:0] cmd = bus_data[63:60];
	wire logic [1:0] len = bus_data[31:30];
	wire logic [4:0] idl = commander_identifier_lines;
	wire logic is_cmd = bus_func == `FN_CMD;
	wire logic rd_c = is_cmd && (cmd == `CMD_READ || cmd == `CMD_ILOCK);
	wire logic wr_c = is_cmd && (cmd == `CMD_WMASK || cmd == `CMD_UNLOCK);
	// read data cycles back to back
	sequence s_burst4;
		bus_func[2] [*4];
	endsequence
	// the two data cycles of an octaword write
	sequence s_wd2;
		(bus_func == `FN_WDATA) [*2];
	endsequence
	// idle counts too: undriven lines give good parity
	property p_par;
		^{bus_data, bus_func, idl, bus_parity_line} == 1'b0;
	endproperty
	a_par: assert property (p_par) else $error("bus parity odd");
	property p_wd;
		bus_func == `FN_WDATA |-> c_oe && !r_oe && idl == MY_ID;
	endproperty
	a_wd: assert property (p_wd) else $error("write data id");
	property p_rid;
		(bus_func[2] || bus_func == `FN_NDR) |-> r_oe && idl == MY_ID;
	endproperty
	a_rid: assert property (p_rid) else $error("response id");
	property p_ndr;
		bus_func == `FN_NDR |-> bus_data[61:0] == 62'h0;
	endproperty
	a_ndr: assert property (p_ndr) else $error("ndr filler");
	// sequence bit must toggle between adjacent data cycles
	property p_seq;
		(bus_func[2] ##1 bus_func[2]) |-> bus_func[0] != $past(bus_func[0]);
	endproperty
	a_seq: assert property (p_seq) else $error("sequence bit");
	// the responder registers its drive, so the first answer cycle
	// comes two cycles after the command cycle
	property p_rd1;
		rd_c |=> ##1 bus_func == `FN_GRD || bus_func == `FN_CRD
			|| bus_func == `FN_NDR;
	endproperty
	a_rd1: assert property (p_rd1) else $error("read answer");
	property p_hexa;
		rd_c && len == `LEN_HEXA |=> ##1 (bus_func == `FN_NDR or s_burst4);
	endproperty
	a_hexa: assert property (p_hexa) else $error("hexa burst");
	property p_owr;
		wr_c && len == `LEN_OCTA |=> s_wd2;
	endproperty
	a_owr: assert property (p_owr) else $error("octa write");
	property p_qwr;
		wr_c && len != `LEN_OCTA |=> bus_func == `FN_WDATA
			##1 bus_func != `FN_WDATA;
	endproperty
	a_qwr: assert property (p_qwr) else $error("single write");
	// deferred i/o write ends with a successful ndr: data cycle, one
	// cycle to latch it, one to register the answer
	property p_io;
		wr_c && bus_data[29] && len == `LEN_LONG |=> ##2
			bus_func == `FN_NDR && bus_data[63:62] == `NDR_OK;
	endproperty
	a_io: assert property (p_io) else $error("io write ndr");
endmodule
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bus_params.svh"
module tb_top;
	localparam logic [4:0] ID = 5'h02; // commander id
	logic clk = 1'b0;
	logic rst = 1'b1;
	// commander user side, driven at the falling edge
	logic req_valid = 1'b0;
	logic [3:0] req_cmd = 4'h0;
	logic [1:0] req_len = 2'h0;
	logic [29:0] req_addr = 30'h0;
	logic [15:0] req_mask = 16'h0;
	logic [63:0] req_wdata0 = 64'h0;
	logic [63:0] req_wdata1 = 64'h0;
	logic word_mode = 1'b0;
	logic corr_inject = 1'b0;
	logic uncorr_inject = 1'b0;
	logic req_ready, rd_valid, rd_corr, seq_err, ndr_valid;
	logic c_perr, r_perr, locked;
	logic [63:0] rd_data;
	logic [1:0] ndr_code;
	// answers gathered per transaction
	logic [63:0] q[$];
	logic [63:0] m[4]; // expected memory
	logic nv, cv, bad = 1'b0;
	logic [1:0] nc;
	int n_fail = 0;
	int num_checks = 0;
	int cyc = 0;
	bus_if bif();
	bus_commander #(.MY_ID(ID)) bus_commander_i (.clk, .rst, .bus(bif),
		.req_valid, .req_cmd, .req_len, .req_addr, .req_mask,
		.req_wdata0, .req_wdata1, .req_ready, .rd_valid, .rd_data,
		.rd_corr, .seq_err, .ndr_valid, .ndr_code, .parity_err(c_perr));
	bus_responder #(.AW(4)) bus_responder_i (.clk, .rst, .bus(bif),
		.word_mode, .corr_inject, .uncorr_inject, .locked,
		.parity_err(r_perr));
	bus_asserts #(.MY_ID(ID)) bus_asserts_i (.clk, .rst,
		.c_oe(bif.c_oe), .r_oe(bif.r_oe), .bus_func(bif.bus_func),
		.commander_identifier_lines(bif.commander_identifier_lines),
		.bus_data(bif.bus_data), .bus_parity_line(bif.bus_parity_line));
	// 200 MHz
	always #2.5 clk = ~clk;
	// collect pulses mid-cycle, away from the edge that launches them;
	// a hang ends the run as a failure
	always @(negedge clk)
	begin
		cyc++;
		if (rd_valid)
		begin
			q.push_back(rd_data);
			cv = rd_corr;
		end
		if (ndr_valid)
		begin
			nv = 1'b1;
			nc = ndr_code;
		end
		if (seq_err | c_perr | r_perr)
			bad = 1'b1;
		if (cyc == 3000)
		begin
			n_fail++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("checks %0d n_fail %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		num_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("Error at %0t got %h expected %h", $time, g, e);
		end
	endtask
	// one transaction: held until taken, then run back to idle
	task automatic req(input logic [3:0] c, input logic [1:0] l,
		input logic [29:0] a, input logic [15:0] k,
		input logic [63:0] w0, input logic [63:0] w1);
		@(negedge clk);
		q.delete();
		{nv, cv} = 2'h0;
		{req_valid, req_cmd, req_len, req_addr} = {1'b1, c, l, a};
		{req_mask, req_wdata0, req_wdata1} = {k, w0, w1};
		do
			@(posedge clk);
		while (req_ready !== 1'b1);
		@(negedge clk);
		req_valid = 1'b0;
		while (req_ready !== 1'b1)
			@(negedge clk);
		repeat (2)
			@(negedge clk);
	endtask
	task automatic rd(input logic [3:0] c, input logic [1:0] l,
		input logic [29:0] a);
		req(c, l, a, 16'h0, 64'h0, 64'h0);
	endtask
	initial
	begin
		m = '{64'h1111_2222_3333_4444, 64'h5555_6666_7777_8888,
			64'h9999_AAAA_BBBB_CCCC, 64'hDDDD_EEEE_FFFF_0123};
		repeat (12)
			@(negedge clk);
		rst = 1'b0;
		req(`CMD_WMASK, `LEN_QUAD, 30'h00, 16'h00FF, m[0], 64'h0);
		req(`CMD_WMASK, `LEN_QUAD, 30'h08, 16'h00FF, m[1], 64'h0);
		req(`CMD_WMASK, `LEN_OCTA, 30'h10, 16'hFFFF, m[2], m[3]);
		// wrapped hexaword starts at the addressed quadword
		rd(`CMD_READ, `LEN_HEXA, 30'h18);
		chk(64'(q.size()), 64'h4);
		chk(q[0], m[3]);
		chk(q[1], m[0]);
		chk(q[2], m[1]);
		chk(q[3], m[2]);
		rd(`CMD_READ, `LEN_OCTA, 30'h18);
		chk(q[0], m[3]);
		chk(q[1], m[2]);
		// partly masked quadword keeps its other bytes
		req(`CMD_WMASK, `LEN_QUAD, 30'h08, 16'h000F, 64'h0, 64'h0);
		m[1][31:0] = 32'h0;
		rd(`CMD_READ, `LEN_QUAD, 30'h08);
		chk(q[0], m[1]);
		// a clean read must not claim a correction
		chk(64'(cv), 64'h0);
		// upper half of longword write data must not land
		req(`CMD_WMASK, `LEN_LONG, 30'h04, 16'h000F,
			64'hFFFF_FFFF_CAFE_F00D, 64'h0);
		m[0][63:32] = 32'hCAFE_F00D;
		rd(`CMD_READ, `LEN_LONG, 30'h04);
		chk(q[0], {32'h0, m[0][63:32]});
		rd(`CMD_READ, `LEN_LONG, 30'h06);
		chk(q[0], {32'h0, m[0][63:32]});
		word_mode = 1'b1;
		rd(`CMD_READ, `LEN_LONG, 30'h06);
		chk(q[0], {32'h0, m[0][63:48], 16'h0});
		rd(`CMD_READ, `LEN_LONG, 30'h04);
		chk(q[0], {48'h0, m[0][47:32]});
		word_mode = 1'b0;
		corr_inject = 1'b1;
		rd(`CMD_READ, `LEN_QUAD, 30'h10);
		chk(q[0], m[2]);
		chk(64'(cv), 64'h1);
		corr_inject = 1'b0;
		uncorr_inject = 1'b1;
		rd(`CMD_READ, `LEN_QUAD, 30'h10);
		chk(64'({nv, nc}), 64'h7);
		uncorr_inject = 1'b0;
		// tag, read refused, full write clears the tag
		rd(`CMD_TAGBAD, `LEN_QUAD, 30'h00);
		rd(`CMD_READ, `LEN_QUAD, 30'h00);
		chk(64'({nv, nc}), 64'h6);
		req(`CMD_WMASK, `LEN_QUAD, 30'h00, 16'h00FF, m[0], 64'h0);
		rd(`CMD_READ, `LEN_QUAD, 30'h00);
		chk(q[0], m[0]);
		// lock taken, second try refused, unlock write releases
		rd(`CMD_ILOCK, `LEN_QUAD, 30'h08);
		chk(q[0], m[1]);
		chk(64'(locked), 64'h1);
		rd(`CMD_ILOCK, `LEN_QUAD, 30'h08);
		chk(64'({nv, nc}), 64'h5);
		req(`CMD_UNLOCK, `LEN_QUAD, 30'h08, 16'h00F0,
			64'hAAAA_BBBB_0000_0000, 64'h0);
		m[1][63:32] = 32'hAAAA_BBBB;
		chk(64'(locked), 64'h0);
		rd(`CMD_READ, `LEN_QUAD, 30'h08);
		chk(q[0], m[1]);
		// deferred i/o write, mask zero so memory is untouched
		req(`CMD_WMASK, `LEN_LONG, 30'h2000_0000, 16'h0, 64'h0, 64'h0);
		chk(64'({nv, nc}), 64'h4);
		chk(64'(bad), 64'h0);
		stop_test();
	end
endmodule
`default_nettype wire
